// *** core/pirf_defs.svh ***
/*
 * Constants of the peripheral request flag block: register offsets,
 * field positions, implemented-bit masks and reset values.
 * Assumes inclusion by bare name from the core files.
 */
`ifndef PIRF_DEFS_SVH
`define PIRF_DEFS_SVH

// Register byte offsets
`define PIRF_OFF_FLAGS_A   12'h000
`define PIRF_OFF_FLAGS_B   12'h004
`define PIRF_OFF_IRQ_STAT  12'h008
`define PIRF_OFF_IRQ_MASK  12'h00C

// Register A field positions
`define PIRF_A_OSC_FAIL    7
`define PIRF_A_CMP_TWO     6
`define PIRF_A_CMP_ONE     5
`define PIRF_A_EE_DONE     4
`define PIRF_A_BUS_COLL    3
`define PIRF_A_CCP_TWO     0

// Register B field positions
`define PIRF_B_CCP_FOUR    5
`define PIRF_B_CCP_THREE   4
`define PIRF_B_TMR_SIX     3
`define PIRF_B_TMR_FOUR    1

// Implemented bits and reset values
`define PIRF_IMPL_A        8'hF9
`define PIRF_IMPL_B        8'h3A
`define PIRF_RST_FLAGS     8'h00
`define PIRF_RST_IRQ       16'h0000

// AXI responses
`define PIRF_RESP_OKAY     2'h0
`define PIRF_RESP_SLVERR   2'h2

`endif

// *** core/pirf_pkg.sv ***
/*
 * Types of the peripheral request flag block.
 * Assumes pirf_defs.svh holds all numeric constants.
 */
package pirf_pkg;

  // Write channel state, one-hot
  typedef enum logic [1:0] {
    PIRF_WS_IDLE = 2'b01,
    PIRF_WS_RESP = 2'b10
  } pirf_wr_state_t;

  typedef logic [7:0] pirf_byte_t;

endpackage : pirf_pkg

// *** core/pirf_flag_if.sv ***
/*
 * Carrier between the register front end and the flag bank.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/100ps
interface pirf_flag_if;
  import pirf_pkg::*;

  pirf_byte_t set_a;
  pirf_byte_t set_b;
  logic       wr_a;
  logic       wr_b;
  pirf_byte_t wdata;
  pirf_byte_t flags_a;
  pirf_byte_t flags_b;

  modport ctl  (output set_a, set_b, wr_a, wr_b, wdata, input flags_a, flags_b);
  modport bank (input set_a, set_b, wr_a, wr_b, wdata, output flags_a, flags_b);
endinterface : pirf_flag_if

// *** core/pirf_flag_bank.sv ***
/*
 * Bank of the two 8-bit request flag registers.
 * Assumes set pulses and writes arrive on sys_clk; reset synchronous.
 */
`timescale 1ns/100ps
`include "pirf_defs.svh"
module pirf_flag_bank (
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  // Flag access
  pirf_flag_if.bank  fl
);
  import pirf_pkg::*;

  localparam logic [15:0] IMPL = {`PIRF_IMPL_B, `PIRF_IMPL_A};

  logic [15:0] set_all;
  logic [15:0] wr_all;
  logic [15:0] flag_q;

  assign set_all = {fl.set_b, fl.set_a};
  assign wr_all  = {{8{fl.wr_b}}, {8{fl.wr_a}}};

  // One flop per implemented bit; unimplemented bits stay zero
  genvar i;
  for (i = 0; i < 16; i++) begin : g_flag
    if (IMPL[i]) begin : g_impl
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          flag_q[i] <= 1'b0;
        end else if (set_all[i]) begin
          flag_q[i] <= 1'b1;
        end else if (wr_all[i]) begin
          flag_q[i] <= fl.wdata[i % 8];
        end
      end
    end else begin : g_none
      assign flag_q[i] = 1'b0;
    end
  end

  assign fl.flags_a = flag_q[7:0];
  assign fl.flags_b = flag_q[15:8];
endmodule : pirf_flag_bank

// *** core/pirf_match.sv ***
/*
 * Timer-to-period match detectors, one per timer.
 * Assumes counts and periods come from timers on sys_clk.
 */
`timescale 1ns/100ps
module pirf_match #(
  parameter int N = 2,
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Timer state
  input  wire logic [W-1:0] count  [N],
  input  wire logic [W-1:0] period [N],
  // Match pulses
  output logic [N-1:0]      hit
);
  logic [N-1:0] eq_q;

  // Pulse on the first cycle of equality so a held match fires once
  genvar t;
  for (t = 0; t < N; t++) begin : g_tmr
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        eq_q[t] <= 1'b0;
      end else begin
        eq_q[t] <= (count[t] == period[t]);
      end
    end
    assign hit[t] = (count[t] == period[t]) & ~eq_q[t];
  end
endmodule : pirf_match

// *** core/pirf_top.sv ***
/*
 * Peripheral request flag block: two flag registers, an interrupt
 * status/mask pair and an AXI4-Lite slave.
 * Assumes event pulses and timer values are synchronous to sys_clk.
 */
`timescale 1ns/100ps
`include "pirf_defs.svh"
module pirf_top #(
  parameter int AW = 12
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // AXI4-Lite write address
  input  wire logic [AW-1:0]       s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0]       s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Peripheral event pulses
  input  wire logic                osc_fail_evt,
  input  wire logic                cmp_two_evt,
  input  wire logic                cmp_one_evt,
  input  wire logic                ee_done_evt,
  input  wire logic                bus_coll_evt,
  input  wire logic                ccp_two_evt,
  input  wire logic                ccp_three_evt,
  input  wire logic                ccp_four_evt,
  // Timer counts and periods
  input  wire logic [7:0]          timer_four_count,
  input  wire logic [7:0]          timer_four_period,
  input  wire logic [7:0]          timer_six_count,
  input  wire logic [7:0]          timer_six_period,
  // Flag and interrupt outputs
  output pirf_pkg::pirf_byte_t     peripheral_request_flags_a,
  output pirf_pkg::pirf_byte_t     peripheral_request_flags_b,
  output logic                     irq
);
  import pirf_pkg::*;

  pirf_flag_if fl ();

  pirf_wr_state_t  wr_state_q;
  pirf_wr_state_t  wr_state_d;
  logic            aw_held_q;
  logic            w_held_q;
  logic            aw_held_d;
  logic            w_held_d;
  logic [AW-1:0]   awaddr_q;
  logic [31:0]     wdata_q;
  logic [3:0]      wstrb_q;
  logic            awready_q;
  logic            wready_q;
  logic            bvalid_q;
  logic [1:0]      bresp_q;
  logic            arready_q;
  logic            rvalid_q;
  logic [31:0]     rdata_q;
  logic [1:0]      rresp_q;
  logic [15:0]     irq_stat_q;
  logic [15:0]     irq_mask_q;
  logic            irq_q;
  logic            wr_fire;
  logic            wr_lo;
  logic [AW-1:0]   wr_addr;
  logic [AW-1:0]   rd_addr;
  logic            wr_known;
  logic            rd_known;
  logic [31:0]     rd_mux;
  logic [1:0]      tmr_hit;
  logic [7:0]      tmr_count  [2];
  logic [7:0]      tmr_period [2];
  logic [15:0]     evt_all;

  localparam logic [15:0] IMPL = {`PIRF_IMPL_B, `PIRF_IMPL_A};

  // Timer match detection, index 0 timer four, index 1 timer six
  assign tmr_count[0]  = timer_four_count;
  assign tmr_count[1]  = timer_six_count;
  assign tmr_period[0] = timer_four_period;
  assign tmr_period[1] = timer_six_period;

  pirf_match #(.N(2), .W(8)) u_match (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .count   (tmr_count),
    .period  (tmr_period),
    .hit     (tmr_hit)
  );

  // Event vectors placed at their flag positions
  always_comb begin
    fl.set_a = `PIRF_RST_FLAGS;
    fl.set_b = `PIRF_RST_FLAGS;
    fl.set_a[`PIRF_A_OSC_FAIL]  = osc_fail_evt;
    fl.set_a[`PIRF_A_CMP_TWO]   = cmp_two_evt;
    fl.set_a[`PIRF_A_CMP_ONE]   = cmp_one_evt;
    fl.set_a[`PIRF_A_EE_DONE]   = ee_done_evt;
    fl.set_a[`PIRF_A_BUS_COLL]  = bus_coll_evt;
    fl.set_a[`PIRF_A_CCP_TWO]   = ccp_two_evt;
    fl.set_b[`PIRF_B_CCP_FOUR]  = ccp_four_evt;
    fl.set_b[`PIRF_B_CCP_THREE] = ccp_three_evt;
    fl.set_b[`PIRF_B_TMR_SIX]   = tmr_hit[1];
    fl.set_b[`PIRF_B_TMR_FOUR]  = tmr_hit[0];
  end
  assign evt_all = {fl.set_b, fl.set_a};

  pirf_flag_bank u_bank (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .fl      (fl)
  );

  // Write address decode
  assign wr_addr  = {awaddr_q[AW-1:2], 2'b00};
  assign rd_addr  = {s_axi_araddr[AW-1:2], 2'b00};
  assign wr_fire  = (wr_state_q == PIRF_WS_IDLE) & aw_held_q & w_held_q;
  assign wr_lo    = wr_fire & wstrb_q[0];
  assign wr_known = (wr_addr == `PIRF_OFF_FLAGS_A) | (wr_addr == `PIRF_OFF_FLAGS_B) |
                    (wr_addr == `PIRF_OFF_IRQ_STAT) | (wr_addr == `PIRF_OFF_IRQ_MASK);
  assign fl.wr_a  = wr_lo & (wr_addr == `PIRF_OFF_FLAGS_A);
  assign fl.wr_b  = wr_lo & (wr_addr == `PIRF_OFF_FLAGS_B);
  assign fl.wdata = wdata_q[7:0];

  // Write channel sequencing
  always_comb begin
    aw_held_d  = (aw_held_q | (s_axi_awvalid & awready_q)) & ~wr_fire;
    w_held_d   = (w_held_q | (s_axi_wvalid & wready_q)) & ~wr_fire;
    wr_state_d = wr_state_q;
    case (wr_state_q)
      PIRF_WS_IDLE: if (wr_fire) wr_state_d = PIRF_WS_RESP;
      PIRF_WS_RESP: if (s_axi_bready) wr_state_d = PIRF_WS_IDLE;
      default:      wr_state_d = PIRF_WS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wr_state_q <= PIRF_WS_IDLE;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
    end else begin
      wr_state_q <= wr_state_d;
      aw_held_q  <= aw_held_d;
      w_held_q   <= w_held_d;
      awready_q  <= ~aw_held_d & (wr_state_d == PIRF_WS_IDLE) & ~wr_fire;
      wready_q   <= ~w_held_d & (wr_state_d == PIRF_WS_IDLE) & ~wr_fire;
      if (s_axi_awvalid & awready_q) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response, error on unmapped offset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `PIRF_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? `PIRF_RESP_OKAY : `PIRF_RESP_SLVERR;
    end else if (bvalid_q & s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Interrupt status (write one to clear, events win) and mask
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_stat_q <= `PIRF_RST_IRQ;
      irq_mask_q <= `PIRF_RST_IRQ;
      irq_q      <= 1'b0;
    end else begin
      if (wr_fire & (wr_addr == `PIRF_OFF_IRQ_STAT)) begin
        irq_stat_q <= ((irq_stat_q & ~wdata_q[15:0]) | evt_all) & IMPL;
      end else begin
        irq_stat_q <= (irq_stat_q | evt_all) & IMPL;
      end
      if (wr_fire & (wr_addr == `PIRF_OFF_IRQ_MASK)) begin
        irq_mask_q <= wdata_q[15:0] & IMPL;
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read decode
  always_comb begin
    rd_mux   = 32'h0000_0000;
    rd_known = 1'b1;
    case (rd_addr)
      `PIRF_OFF_FLAGS_A:  rd_mux[7:0]  = fl.flags_a;
      `PIRF_OFF_FLAGS_B:  rd_mux[7:0]  = fl.flags_b;
      `PIRF_OFF_IRQ_STAT: rd_mux[15:0] = irq_stat_q;
      `PIRF_OFF_IRQ_MASK: rd_mux[15:0] = irq_mask_q;
      default:            rd_known     = 1'b0;
    endcase
  end

  // Read channel, one read at a time
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `PIRF_RESP_OKAY;
    end else if (s_axi_arvalid & arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= rd_known ? `PIRF_RESP_OKAY : `PIRF_RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q  <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign peripheral_request_flags_a = fl.flags_a;
  assign peripheral_request_flags_b = fl.flags_b;
  assign irq = irq_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  evt_sets_a: assert property (osc_fail_evt |=> peripheral_request_flags_a[7])
    else $error("oscillator fail event did not set its flag");
  rd_flag_a: assert property (s_axi_arvalid & arready_q & (rd_addr == `PIRF_OFF_FLAGS_A)
      |=> s_axi_rvalid & (s_axi_rdata[7:0] == $past(fl.flags_a)))
    else $error("flag register A read returned wrong value");
  unimpl_a_a: assert property (peripheral_request_flags_a[2:1] == 2'h0)
    else $error("register A unimplemented bits not zero");
  unimpl_b_a: assert property ((peripheral_request_flags_b & 8'hC5) == 8'h00)
    else $error("register B unimplemented bits not zero");
  tmr_six_a: assert property ((timer_six_count == timer_six_period) &&
      !$past(timer_six_count == timer_six_period) |=> peripheral_request_flags_b[3])
    else $error("timer six match did not set its flag");
  clr_ccp4_a: assert property (fl.wr_b & !fl.wdata[5] & !ccp_four_evt
      |=> !peripheral_request_flags_b[5])
    else $error("capture four flag not zero after clear");
  flag_hold_a: assert property (peripheral_request_flags_a[5] & !fl.wr_a
      |=> peripheral_request_flags_a[5])
    else $error("comparator one flag dropped without write");
  wr_resp_a: assert property (wr_fire |=> s_axi_bvalid ##0 !s_axi_awready [*1])
    else $error("write response missing after write");
  wr_b_set_a: assert property (fl.wr_b & fl.wdata[3]
      |=> peripheral_request_flags_b[3])
    else $error("timer six flag not set by software write");
  set_wins_a: assert property (fl.wr_a & !fl.wdata[7] & osc_fail_evt
      |=> peripheral_request_flags_a[7])
    else $error("oscillator fail event lost to a same-cycle clear");
  rd_resp_a: assert property (s_axi_arvalid & arready_q |=> s_axi_rvalid)
    else $error("read response missing after address handshake");

  // Interrupt status capture and level output
  stat_set_a: assert property (|evt_all
      |=> ((irq_stat_q & $past(evt_all)) == $past(evt_all)))
    else $error("event did not set its interrupt status bit");
  irq_on_a: assert property (|(irq_stat_q & irq_mask_q) |=> irq)
    else $error("interrupt output low with unmasked status set");
  irq_off_a: assert property (!(|(irq_stat_q & irq_mask_q)) |=> !irq)
    else $error("interrupt output high with no unmasked status");

  cov_evt: cover property (ccp_two_evt ##1 peripheral_request_flags_a[0]);
  cov_clr: cover property (fl.wr_a & (fl.wdata == 8'h00) & (fl.flags_a != 8'h00));
  cov_irq: cover property ($rose(irq));
  cov_wins: cover property (fl.wr_a & !fl.wdata[7] & osc_fail_evt);
  cov_tmr: cover property (tmr_hit[0] ##1 peripheral_request_flags_b[1]);
endmodule : pirf_top

// *** verif/pirf_tb.sv ***
/*
 * Self-checking bench of the peripheral request flag block.
 * Assumes pirf_top with AW=12 and registers at the offsets of pirf_defs.svh.
 */
`timescale 1ns/100ps
`include "pirf_defs.svh"
module testbench;
  import pirf_pkg::*;

  logic        sys_clk, rst_b;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  evt;
  logic [7:0]  t4c, t4p, t6c, t6p;
  pirf_byte_t  fa, fb;
  logic        irq;
  int          mismatches, n_checks, cyc;
  logic [15:0] lf;
  logic [31:0] rd;
  logic [1:0]  rs;

  pirf_top uut (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_fail_evt(evt[7]), .cmp_two_evt(evt[6]), .cmp_one_evt(evt[5]),
    .ee_done_evt(evt[4]), .bus_coll_evt(evt[3]), .ccp_two_evt(evt[0]),
    .ccp_three_evt(evt[1]), .ccp_four_evt(evt[2]),
    .timer_four_count(t4c), .timer_four_period(t4p),
    .timer_six_count(t6c), .timer_six_period(t6p),
    .peripheral_request_flags_a(fa), .peripheral_request_flags_b(fb), .irq(irq)
  );

  // Clock of 8 ns
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  // Next value of the stimulus generator
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // Expected register A from event vector bits
  function automatic logic [7:0] exp_a(input logic [7:0] e);
    return e & 8'hF9;
  endfunction : exp_a

  // Expected register B: capture three at 4, capture four at 5
  function automatic logic [7:0] exp_b(input logic [7:0] e);
    return {2'h0, e[2], e[1], 4'h0};
  endfunction : exp_b

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic done(input string what);
    $display("test %s done", what);
  endtask : done

  // One AXI4-Lite write, address and data offered together
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    @(posedge sys_clk);
  endtask : axi_wr

  // One AXI4-Lite read
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    @(posedge sys_clk);
  endtask : axi_rd

  // Write then read back one register
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    axi_wr(a, d, rs);
    chk("bresp", rs, `PIRF_RESP_OKAY);
    axi_rd(a, rd, rs);
    chk("rresp", rs, `PIRF_RESP_OKAY);
    chk("rdata", rd, exp);
  endtask : wr_rd

  // Single-cycle event pulse on the given sources
  task automatic pulse(input logic [7:0] e);
    evt <= e;
    @(posedge sys_clk);
    evt <= 8'h00;
    @(posedge sys_clk);
  endtask : pulse

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  initial begin
    logic [7:0] e;
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    lf = 16'd45188;
    rst_b = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    evt = 8'h00;
    t4c = 8'h00;
    t6c = 8'h00;
    t4p = 8'hFF;
    t6p = 8'hFF;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // Reset values
    axi_rd(`PIRF_OFF_FLAGS_A, rd, rs);
    chk("flags_a reset", rd, 32'h0);
    axi_rd(`PIRF_OFF_FLAGS_B, rd, rs);
    chk("flags_b reset", rd, 32'h0);
    chk("irq reset", irq, 1'b0);
    done("reset");
    // Software set and clear, unimplemented bits read zero
    wr_rd(`PIRF_OFF_FLAGS_A, 32'hFF, 32'hF9);
    wr_rd(`PIRF_OFF_FLAGS_B, 32'hFF, 32'h3A);
    wr_rd(`PIRF_OFF_FLAGS_A, 32'h00, 32'h00);
    wr_rd(`PIRF_OFF_FLAGS_B, 32'h00, 32'h00);
    // Low strobe lane off: a write of ones leaves the flags alone
    wstrb <= 4'hE;
    axi_wr(`PIRF_OFF_FLAGS_A, 32'hFF, rs);
    wstrb <= 4'hF;
    axi_rd(`PIRF_OFF_FLAGS_A, rd, rs);
    chk("flags_a strobe off", rd, 32'h0);
    // Event in the cycle the clear lands: the set wins
    fork
      axi_wr(`PIRF_OFF_FLAGS_A, 32'h0, rs);
      begin
        @(posedge sys_clk);
        evt <= 8'h80;
        @(posedge sys_clk);
        evt <= 8'h00;
      end
    join
    axi_rd(`PIRF_OFF_FLAGS_A, rd, rs);
    chk("set beats clear", rd, 32'h80);
    wr_rd(`PIRF_OFF_FLAGS_A, 32'h00, 32'h00);
    done("software access");
    // One-hot events then random event mixes, enables all off
    for (int i = 0; i < 20; i++) begin
      lf = lfsr(lf);
      e = (i < 8) ? (8'h01 << i) : lf[7:0];
      pulse(e);
      chk("flags_a port", fa, exp_a(e));
      chk("flags_b port", fb, exp_b(e));
      repeat (3) @(posedge sys_clk);
      axi_rd(`PIRF_OFF_FLAGS_B, rd, rs);
      chk("flags_b held", rd, {24'h0, exp_b(e)});
      wr_rd(`PIRF_OFF_FLAGS_A, 32'h0, 32'h0);
      wr_rd(`PIRF_OFF_FLAGS_B, 32'h0, 32'h0);
    end
    done("events");
    // Random software values
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      wr_rd(`PIRF_OFF_FLAGS_A, {24'h0, lf[7:0]}, {24'h0, lf[7:0] & 8'hF9});
      wr_rd(`PIRF_OFF_FLAGS_B, {24'h0, lf[15:8]}, {24'h0, lf[15:8] & 8'h3A});
    end
    wr_rd(`PIRF_OFF_FLAGS_A, 32'h0, 32'h0);
    wr_rd(`PIRF_OFF_FLAGS_B, 32'h0, 32'h0);
    done("random writes");
    // Timer match: set once on equality, a held match does not set again
    t4p <= 8'h5A;
    t6p <= 8'hA5;
    @(posedge sys_clk);
    t4c <= 8'h5A;
    repeat (3) @(posedge sys_clk);
    chk("timer four match", fb, 8'h02);
    t6c <= 8'hA5;
    repeat (3) @(posedge sys_clk);
    chk("timer six match", fb, 8'h0A);
    wr_rd(`PIRF_OFF_FLAGS_B, 32'h0, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk("held match", fb, 8'h00);
    t4c <= 8'h00;
    t6c <= 8'h00;
    repeat (2) @(posedge sys_clk);
    t4c <= 8'h5A;
    repeat (3) @(posedge sys_clk);
    chk("second match", fb, 8'h02);
    wr_rd(`PIRF_OFF_FLAGS_B, 32'h0, 32'h0);
    done("timer match");
    // Interrupt status, mask and level output
    // Stale status cleared before any mask bit is enabled
    axi_wr(`PIRF_OFF_IRQ_STAT, 32'hFFFF, rs);
    wr_rd(`PIRF_OFF_IRQ_MASK, 32'h0, 32'h0);
    pulse(8'h84);
    axi_rd(`PIRF_OFF_IRQ_STAT, rd, rs);
    chk("irq status", rd, 32'h2080);
    chk("irq masked", irq, 1'b0);
    wr_rd(`PIRF_OFF_IRQ_MASK, 32'h2000, 32'h2000);
    repeat (2) @(posedge sys_clk);
    chk("irq raised", irq, 1'b1);
    axi_wr(`PIRF_OFF_IRQ_STAT, 32'h2000, rs);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", irq, 1'b0);
    axi_rd(`PIRF_OFF_IRQ_STAT, rd, rs);
    chk("irq status w1c", rd, 32'h0080);
    done("interrupt");
    // Unmapped address
    axi_wr(12'h010, 32'hFF, rs);
    chk("unmapped bresp", rs, `PIRF_RESP_SLVERR);
    axi_rd(12'h010, rd, rs);
    chk("unmapped rresp", rs, `PIRF_RESP_SLVERR);
    chk("unmapped rdata", rd, 32'h0);
    chk("flags_a untouched", fa, 8'h84 & 8'hF9);
    done("unmapped");
    // Mid-run reset clears every flag and the interrupt
    t4c <= 8'h00;
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("flags_a after reset", fa, 8'h00);
    chk("flags_b after reset", fb, 8'h00);
    chk("irq after reset", irq, 1'b0);
    axi_rd(`PIRF_OFF_IRQ_STAT, rd, rs);
    chk("irq status after reset", rd, 32'h0);
    done("mid-run reset");
    summarize();
  end
endmodule : testbench
